//--- logic/pqm_monitor.sv
// Power quality event monitor: peaks, over-level events, neutral mismatch
//
// Overview of operation
// [R1] Capture largest absolute sample per window, low 24
// [R2] Window length counted in zero-crossing half cycles
// [R3] Mode bits 4..2 select phases A, B, C
// [R4] Every selected phase's crossing counts toward window
// [R5] One phase flag in bits 26..24 per peak
// [R6] Peak updated at window end, held meanwhile
// [R7] Window end sets status bits 23, 24
// [R8] Write one clears status; interrupt released when none
// [R9] Half-cycle count write restarts crossing counter, only while a phase is selected in mode bits 4..2
// [R10] Overvoltage sets bit 18 and phase bit
// [R11] Clearing bit 18 clears voltage phase bits
// [R12] Overcurrent sets bit 17, phase bits 5..3
// [R13] Over-level interrupts gated by enable 18, 17
// [R14] Full-scale threshold never trips; zero always trips
// [R15] Excess thresholds read with eight zero MSBs
// [R16] Sum three phase currents per sample, 28 bits
// [R17] Done flag bit 17 marks fresh sum
// [R18] Mismatch bit 20 when difference exceeds threshold
// [R19] Enable 20 gates mismatch interrupt; one clears
// [R20] Mismatch threshold signed, resets zero, nonpositive trips
// [R21] Sum, mismatch threshold read with four zero MSBs
// [R22] Host reads phase info before clearing flag
// [R23] Host loads positive mismatch threshold after reset
// [R24] Negative-to-positive crossings are timing references
// [R25] Comparisons once per sample on absolute values
`include "pqm_consts.svh"

module pqm_monitor #(
   parameter int CNT_W = 8 // Width of the half-cycle count
) (
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic clkEn, // Clock enable, freezes state when low
   input wire logic sampleStb, // One pulse per DSP sample set
   input wire pqm_pkg::pqm_tri_sample_t voltSamples, // Signed phase voltages
   input wire pqm_pkg::pqm_tri_sample_t curSamples, // Signed phase currents
   input wire logic [23:0] neutralSample, // Signed neutral current
   input wire logic [2:0] zeroCross, // Rising zero-crossing pulses, A..C
   input wire pqm_pkg::pqm_reg_req_t regReq, // Register access request
   output logic [31:0] regRdData, // Read data, valid with regRdValid
   output logic regRdValid, // Read answer pulse
   output logic event_irq_b_n // Event interrupt, active low
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [23:0] voltage_excess_threshold_reg;
   logic [23:0] current_excess_threshold_reg;
   logic [23:0] sum_mismatch_threshold_reg;
   logic [CNT_W-1:0] peak_half_cycle_count_reg;
   logic [7:0] measurement_mode_reg;
   logic [27:0] phase_current_total_reg;
   logic [31:0] event_status_a_reg;
   logic [31:0] event_status_b_reg;
   logic [31:0] event_enable_b_reg;
   logic [31:0] phase_event_status_reg;
   logic [CNT_W-1:0] crossCount_reg;
   logic [31:0] voltage_peak_capture;
   logic [31:0] current_peak_capture;

   // ----------------------------------------
   // Register port decode
   // ----------------------------------------
   wire wrEn = regReq.wr;
   wire [4:0] idx = regReq.idx;
   wire [31:0] wd = regReq.wdata;
   wire wrVThr = wrEn && (idx == `PQM_IDX_V_EXC_THR);
   wire wrIThr = wrEn && (idx == `PQM_IDX_I_EXC_THR);
   wire wrMThr = wrEn && (idx == `PQM_IDX_MISM_THR);
   wire wrCyc = wrEn && (idx == `PQM_IDX_HALF_CYC);
   wire wrMode = wrEn && (idx == `PQM_IDX_MODE);
   wire wrStA = wrEn && (idx == `PQM_IDX_STATUS_A);
   wire wrStB = wrEn && (idx == `PQM_IDX_STATUS_B);
   wire wrEnB = wrEn && (idx == `PQM_IDX_ENABLE_B);
   wire [31:0] clrA = wrStA ? wd : 32'h0000_0000;
   wire [31:0] clrB = wrStB ? wd : 32'h0000_0000; // [R8]

   wire [2:0] peak_phase_select = measurement_mode_reg[`PQM_MODE_SEL_HI:`PQM_MODE_SEL_LO]; // [R3]

   // ----------------------------------------
   // Zero-crossing window counter
   // ----------------------------------------
   // Only rising crossings arrive here; several phases may cross at once
   wire [2:0] selCross = zeroCross & peak_phase_select; // [R4] [R24]
   wire [1:0] crossInc = 2'(selCross[0]) + 2'(selCross[1]) + 2'(selCross[2]);
   wire [CNT_W:0] crossSum = {1'b0, crossCount_reg} + (CNT_W+1)'(crossInc);
   // A zero count never closes a window
   wire windowEnd = (peak_half_cycle_count_reg != '0) && (crossInc != 2'b00)
                    && (crossSum >= {1'b0, peak_half_cycle_count_reg}); // [R2]
   wire cntRestart = wrCyc && (peak_phase_select != 3'b000); // [R9]

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         crossCount_reg <= '0;
      end else if (clkEn) begin
         if (cntRestart) begin
            crossCount_reg <= '0; // [R9]
         end else if (windowEnd) begin
            crossCount_reg <= '0;
         end else begin
            crossCount_reg <= crossSum[CNT_W-1:0]; // [R2] [R4]
         end
      end
   end

   // ----------------------------------------
   // Peak trackers
   // ----------------------------------------
   pqm_peak_tracker uVoltPeak (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .samples(voltSamples),
      .sampleStb(sampleStb),
      .phaseSel(peak_phase_select),
      .windowEnd(windowEnd),
      .peakWord(voltage_peak_capture)
   );

   pqm_peak_tracker uCurPeak (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .samples(curSamples),
      .sampleStb(sampleStb),
      .phaseSel(peak_phase_select),
      .windowEnd(windowEnd),
      .peakWord(current_peak_capture)
   );

   // ----------------------------------------
   // Over-level detection
   // ----------------------------------------
   logic [2:0][23:0] vAbs;
   logic [2:0][23:0] iAbs;
   logic [2:0] vOver;
   logic [2:0] iOver;

   // Zero means always on; full scale or above can never be reached
   wire vThrZero = (voltage_excess_threshold_reg == 24'h00_0000); // [R14]
   wire iThrZero = (current_excess_threshold_reg == 24'h00_0000); // [R14]
   wire vThrLive = (voltage_excess_threshold_reg < `PQM_FULL_SCALE); // [R14]
   wire iThrLive = (current_excess_threshold_reg < `PQM_FULL_SCALE); // [R14]

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gOver
         assign vAbs[g] = voltSamples.smp[g][23] ? (~voltSamples.smp[g] + 24'h00_0001)
                                                 : voltSamples.smp[g]; // [R25]
         assign iAbs[g] = curSamples.smp[g][23] ? (~curSamples.smp[g] + 24'h00_0001)
                                                : curSamples.smp[g]; // [R25]
         assign vOver[g] = sampleStb && (vThrZero
                           || (vThrLive && (vAbs[g] > voltage_excess_threshold_reg))); // [R10]
         assign iOver[g] = sampleStb && (iThrZero
                           || (iThrLive && (iAbs[g] > current_excess_threshold_reg))); // [R12]
      end
   endgenerate

   // ----------------------------------------
   // Phase current sum and neutral mismatch
   // ----------------------------------------
   wire [27:0] sumNow = 28'({{4{curSamples.smp[0][23]}}, curSamples.smp[0]})
                      + 28'({{4{curSamples.smp[1][23]}}, curSamples.smp[1]})
                      + 28'({{4{curSamples.smp[2][23]}}, curSamples.smp[2]}); // [R16]
   wire [27:0] sumAbs = sumNow[27] ? (~sumNow + 28'h000_0001) : sumNow;
   wire [27:0] neuAbs = neutralSample[23] ? 28'(~neutralSample + 24'h00_0001)
                                          : {4'h0, neutralSample};
   wire [27:0] diffAbs = (sumAbs >= neuAbs) ? (sumAbs - neuAbs) : (neuAbs - sumAbs);
   wire [27:0] mThrExt = {{4{sum_mismatch_threshold_reg[23]}}, sum_mismatch_threshold_reg};
   // A zero or negative threshold trips on every sample
   wire mThrNonPos = sum_mismatch_threshold_reg[23]
                     || (sum_mismatch_threshold_reg == 24'h00_0000); // [R20]
   wire mismatchNow = sampleStb && (mThrNonPos || (diffAbs > mThrExt)); // [R18] [R25]

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phase_current_total_reg <= 28'h000_0000;
      end else if (clkEn && sampleStb) begin
         phase_current_total_reg <= sumNow; // [R16]
      end
   end

   // ----------------------------------------
   // Status set terms
   // ----------------------------------------
   logic [31:0] setA;
   logic [31:0] setB;
   logic [31:0] setPh;
   logic [31:0] clrPh;

   always_comb begin
      setA = 32'h0000_0000;
      setA[`PQM_STA_DSP_DONE] = sampleStb; // [R17]
      setB = 32'h0000_0000;
      setB[`PQM_STB_CUR_EXC] = |iOver; // [R12]
      setB[`PQM_STB_VOLT_EXC] = |vOver; // [R10]
      setB[`PQM_STB_MISMATCH] = mismatchNow; // [R18]
      setB[`PQM_STB_CUR_PEAK] = windowEnd; // [R7]
      setB[`PQM_STB_VOLT_PEAK] = windowEnd; // [R7]
      setPh = 32'h0000_0000;
      setPh[`PQM_PHS_CUR_LO +: 3] = iOver; // [R12]
      setPh[`PQM_PHS_VOLT_LO +: 3] = vOver; // [R10]
      clrPh = 32'h0000_0000;
      clrPh[`PQM_PHS_CUR_LO +: 3] = {3{clrB[`PQM_STB_CUR_EXC]}}; // [R12]
      clrPh[`PQM_PHS_VOLT_LO +: 3] = {3{clrB[`PQM_STB_VOLT_EXC]}}; // [R11]
   end

   // Set beats clear so an event in the clearing cycle survives
   wire [31:0] statusA_next = (event_status_a_reg & ~clrA) | setA; // [R8]
   wire [31:0] statusB_next = (event_status_b_reg & ~clrB) | setB; // [R8]
   wire [31:0] phase_next = (phase_event_status_reg & ~clrPh) | setPh; // [R11]
   // Enable written in this cycle counts at once, so the pin follows the write edge
   wire [31:0] enableB_next = wrEnB ? wd : event_enable_b_reg;
   wire irqActive = |(statusB_next & enableB_next); // [R7] [R13] [R19]

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         voltage_excess_threshold_reg <= `PQM_RST_THR;
         current_excess_threshold_reg <= `PQM_RST_THR;
         sum_mismatch_threshold_reg <= `PQM_RST_MISM_THR; // [R20]
         peak_half_cycle_count_reg <= `PQM_RST_HALF_CYC;
         measurement_mode_reg <= `PQM_RST_MODE;
         event_enable_b_reg <= `PQM_RST_WORD;
      end else if (clkEn) begin
         if (wrVThr) voltage_excess_threshold_reg <= wd[23:0];
         if (wrIThr) current_excess_threshold_reg <= wd[23:0];
         if (wrMThr) sum_mismatch_threshold_reg <= wd[23:0];
         if (wrCyc) peak_half_cycle_count_reg <= wd[CNT_W-1:0];
         if (wrMode) measurement_mode_reg <= wd[7:0];
         if (wrEnB) event_enable_b_reg <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         event_status_a_reg <= `PQM_RST_WORD;
         event_status_b_reg <= `PQM_RST_WORD;
         phase_event_status_reg <= `PQM_RST_WORD;
         event_irq_b_n <= 1'b1;
      end else if (clkEn) begin
         event_status_a_reg <= statusA_next; // [R17]
         event_status_b_reg <= statusB_next; // [R8]
         phase_event_status_reg <= phase_next; // [R11]
         event_irq_b_n <= ~irqActive; // [R8] [R13] [R19]
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [31:0] rdMux;

   always_comb begin
      case (idx)
         `PQM_IDX_VOLTAGE_PEAK_CAPTURE_CAP: rdMux = voltage_peak_capture; // [R1]
         `PQM_IDX_CURRENT_PEAK_CAPTURE_CAP: rdMux = current_peak_capture; // [R1]
         `PQM_IDX_V_EXC_THR: rdMux = {8'h00, voltage_excess_threshold_reg}; // [R15]
         `PQM_IDX_I_EXC_THR: rdMux = {8'h00, current_excess_threshold_reg}; // [R15]
         `PQM_IDX_I_TOTAL: rdMux = {4'h0, phase_current_total_reg}; // [R21]
         `PQM_IDX_MISM_THR: rdMux = {4'h0, mThrExt}; // [R21]
         `PQM_IDX_HALF_CYC: rdMux = 32'(peak_half_cycle_count_reg);
         `PQM_IDX_MODE: rdMux = {24'h00_0000, measurement_mode_reg};
         `PQM_IDX_STATUS_A: rdMux = event_status_a_reg;
         `PQM_IDX_STATUS_B: rdMux = event_status_b_reg;
         `PQM_IDX_ENABLE_B: rdMux = event_enable_b_reg;
         `PQM_IDX_PHASE_STAT: rdMux = phase_event_status_reg;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         regRdData <= `PQM_RST_WORD;
         regRdValid <= 1'b0;
      end else if (clkEn) begin
         regRdValid <= regReq.rd;
         if (regReq.rd) regRdData <= rdMux;
      end
   end

endmodule // pqm_monitor

//--- logic/pqm_consts.svh
// Register indices, field positions, reset values and limits of the event monitor
`ifndef PQM_CONSTS_SVH
`define PQM_CONSTS_SVH

// ----------------------------------------
// Register indices on the register port
// ----------------------------------------
`define PQM_IDX_VOLTAGE_PEAK_CAPTURE_CAP   5'h0_0
`define PQM_IDX_CURRENT_PEAK_CAPTURE_CAP   5'h0_1
`define PQM_IDX_V_EXC_THR   5'h0_2
`define PQM_IDX_I_EXC_THR   5'h0_3
`define PQM_IDX_I_TOTAL     5'h0_4
`define PQM_IDX_MISM_THR    5'h0_5
`define PQM_IDX_HALF_CYC    5'h0_6
`define PQM_IDX_MODE        5'h0_7
`define PQM_IDX_STATUS_A    5'h0_8
`define PQM_IDX_STATUS_B    5'h0_9
`define PQM_IDX_ENABLE_B    5'h0_A
`define PQM_IDX_PHASE_STAT  5'h0_B

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PQM_MODE_SEL_LO     2
`define PQM_MODE_SEL_HI     4
`define PQM_PEAK_FLAG_LO    24
`define PQM_STA_DSP_DONE    17
`define PQM_STB_CUR_EXC     17
`define PQM_STB_VOLT_EXC    18
`define PQM_STB_MISMATCH    20
`define PQM_STB_CUR_PEAK    23
`define PQM_STB_VOLT_PEAK   24
`define PQM_PHS_CUR_LO      3
`define PQM_PHS_VOLT_LO     9

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PQM_FULL_SCALE      24'h51_4791
`define PQM_RST_THR         24'h00_0000
`define PQM_RST_MISM_THR    24'h00_0000
`define PQM_RST_HALF_CYC    8'h00
`define PQM_RST_MODE        8'h00
`define PQM_RST_WORD        32'h0000_0000

`endif

//--- logic/pqm_pkg.sv
// Types shared by the power quality event monitor modules
package pqm_pkg;

   // ----------------------------------------
   // Three signed phase samples, index 0 is phase A
   // ----------------------------------------
   typedef struct packed {
      logic [2:0][23:0] smp;
   } pqm_tri_sample_t;

   // ----------------------------------------
   // Register port request
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] idx;
      logic [31:0] wdata;
   } pqm_reg_req_t;

endpackage : pqm_pkg

//--- logic/pqm_peak_tracker.sv
// Windowed peak tracker for one channel (three phases)
`include "pqm_consts.svh"

module pqm_peak_tracker (
   input wire logic clk_sys, // System clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic clkEn, // Clock enable
   input wire pqm_pkg::pqm_tri_sample_t samples, // Signed phase samples
   input wire logic sampleStb, // New sample set
   input wire logic [2:0] phaseSel, // Phases taking part
   input wire logic windowEnd, // Last cycle of a window
   output logic [31:0] peakWord // Held peak value and phase flag
);

   logic [2:0][23:0] absVal;
   logic [23:0] runMax_reg;
   logic [2:0] runPhase_reg;
   logic [23:0] candMax;
   logic [2:0] candPhase;

   // ----------------------------------------
   // Absolute values
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gAbs
         assign absVal[g] = samples.smp[g][23] ? (~samples.smp[g] + 24'h00_0001)
                                               : samples.smp[g];
      end
   endgenerate

   // Largest selected sample so far; one phase named at a time
   always_comb begin
      candMax = runMax_reg;
      candPhase = runPhase_reg;
      for (int p = 0; p < 3; p++) begin
         if (sampleStb && phaseSel[p] && (absVal[p] > candMax)) begin // [R1] [R3]
            candMax = absVal[p];
            candPhase = 3'b001 << p; // [R5]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         runMax_reg <= 24'h00_0000;
         runPhase_reg <= 3'b000;
         peakWord <= `PQM_RST_WORD;
      end else if (clkEn) begin
         if (windowEnd) begin
            // Held for the whole next window
            peakWord <= {5'h00, candPhase, candMax}; // [R1] [R5] [R6]
            runMax_reg <= 24'h00_0000;
            runPhase_reg <= 3'b000;
         end else begin
            runMax_reg <= candMax;
            runPhase_reg <= candPhase;
         end
      end
   end

endmodule // pqm_peak_tracker

//--- bench/pqm_chk_monitor.sv
// Port-level assertions of the power quality event monitor
`include "pqm_consts.svh"
module pqm_monitor_chk #(
   parameter int CNT_W = 8 // Half-cycle count width
) (
   input logic clk_sys, // Clock
   input logic rst_b, // Reset, active low
   input logic clkEn, // Clock enable
   input logic sampleStb, // Sample strobe
   input pqm_pkg::pqm_tri_sample_t voltSamples, // Voltages
   input pqm_pkg::pqm_tri_sample_t curSamples, // Currents
   input logic [23:0] neutralSample, // Neutral
   input logic [2:0] zeroCross, // Crossings
   input pqm_pkg::pqm_reg_req_t regReq, // Request
   input logic [31:0] regRdData, // Read data
   input logic regRdValid, // Read answer
   input logic event_irq_b_n // Interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rdOn;
   logic quiet;
   assign rdOn = clkEn && regReq.rd;
   assign quiet = clkEn && !sampleStb;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   property p_peak_fmt;
      rdOn && regReq.idx <= `PQM_IDX_CURRENT_PEAK_CAPTURE_CAP |=> regRdValid && regRdData[31:27] == 5'h0_0
         && $onehot0(regRdData[26:24]);
   endproperty
   a_peak_fmt: assert property (p_peak_fmt) else $error("peak word format wrong");
   property p_thr_pad;
      rdOn && (regReq.idx == `PQM_IDX_V_EXC_THR || regReq.idx == `PQM_IDX_I_EXC_THR)
         |=> regRdValid && regRdData[31:24] == 8'h00;
   endproperty
   a_thr_pad: assert property (p_thr_pad) else $error("threshold not zero padded");
   property p_sum_pad;
      rdOn && regReq.idx == `PQM_IDX_I_TOTAL |=> regRdValid && regRdData[31:28] == 4'h0;
   endproperty
   a_sum_pad: assert property (p_sum_pad) else $error("sum not zero padded");
   property p_mthr_ext;
      rdOn && regReq.idx == `PQM_IDX_MISM_THR
         |=> regRdData[31:28] == 4'h0 && regRdData[27:24] == {4{regRdData[23]}};
   endproperty
   a_mthr_ext: assert property (p_mthr_ext) else $error("mismatch level badly extended");
   property p_clr_all;
      quiet && regReq.wr && regReq.idx == `PQM_IDX_STATUS_B && regReq.wdata == 32'hFFFF_FFFF
         && zeroCross == 3'h0 |=> event_irq_b_n;
   endproperty
   a_clr_all: assert property (p_clr_all) else $error("irq kept after full clear");
   property p_irq_cause;
      $fell(event_irq_b_n) |-> $past(clkEn && (sampleStb || zeroCross != 3'h0 || regReq.wr));
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq fell without cause");
   property p_clr_ov;
      quiet && regReq.wr && regReq.idx == `PQM_IDX_STATUS_B && regReq.wdata[18] ##1 quiet
         ##1 rdOn && regReq.idx == `PQM_IDX_PHASE_STAT |=> regRdData[11:9] == 3'h0;
   endproperty
   a_clr_ov: assert property (p_clr_ov) else $error("voltage phase bits kept");
   property p_clr_oi;
      quiet && regReq.wr && regReq.idx == `PQM_IDX_STATUS_B && regReq.wdata[17] ##1 quiet
         ##1 rdOn && regReq.idx == `PQM_IDX_PHASE_STAT |=> regRdData[5:3] == 3'h0;
   endproperty
   a_clr_oi: assert property (p_clr_oi) else $error("current phase bits kept");
   c_irq: cover property ($fell(event_irq_b_n));
   c_cross: cover property (clkEn && zeroCross != 3'h0);
   c_stat: cover property (rdOn && regReq.idx == `PQM_IDX_STATUS_B);
endmodule // pqm_monitor_chk

bind pqm_monitor pqm_monitor_chk #(.CNT_W(CNT_W)) pqm_monitor_chk_i (.clk_sys(clk_sys),
   .rst_b(rst_b), .clkEn(clkEn), .sampleStb(sampleStb), .voltSamples(voltSamples),
   .curSamples(curSamples), .neutralSample(neutralSample), .zeroCross(zeroCross),
   .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
   .event_irq_b_n(event_irq_b_n));

//--- bench/pqm_host_model.sv
// Host model: register port master of the event monitor
module pqm_host_model (
   input logic clk_sys, // Clock
   output pqm_pkg::pqm_reg_req_t regReq, // Request
   input logic [31:0] regRdData, // Read data
   input logic regRdValid // Read answer
);
   timeunit 1ns;
   timeprecision 1ps;
   initial regReq = '0;
   // Idle data is inverted so a stale word is never mistaken for a write
   task automatic wr(input logic [4:0] idx, input logic [31:0] v);
      @(posedge clk_sys);
      #1 regReq = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: v};
      @(posedge clk_sys);
      #1 regReq.wr = 1'b0;
      regReq.wdata = ~v;
   endtask
   task automatic rd(input logic [4:0] idx, output logic [31:0] v);
      @(posedge clk_sys);
      #1 regReq = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: ~regReq.wdata};
      @(posedge clk_sys);
      #1 v = (regRdValid === 1'b1) ? regRdData : 'x;
      regReq.rd = 1'b0;
   endtask
endmodule // pqm_host_model

//--- bench/pqm_monitor_tb.sv
// Self-checking testbench of the power quality event monitor
`include "pqm_consts.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module pqm_monitor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] VPK = `PQM_IDX_VOLTAGE_PEAK_CAPTURE_CAP;
   localparam logic [4:0] IPK = `PQM_IDX_CURRENT_PEAK_CAPTURE_CAP;
   localparam logic [4:0] VTH = `PQM_IDX_V_EXC_THR;
   localparam logic [4:0] ITH = `PQM_IDX_I_EXC_THR;
   localparam logic [4:0] SUM = `PQM_IDX_I_TOTAL;
   localparam logic [4:0] MTH = `PQM_IDX_MISM_THR;
   localparam logic [4:0] STA = `PQM_IDX_STATUS_A;
   localparam logic [4:0] STB = `PQM_IDX_STATUS_B;
   localparam logic [4:0] ENB = `PQM_IDX_ENABLE_B;
   localparam logic [4:0] PHS = `PQM_IDX_PHASE_STAT;
   localparam logic [23:0] FS = `PQM_FULL_SCALE;
   localparam logic [23:0] NFS = -`PQM_FULL_SCALE;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic clkEn = 1'b1;
   logic sampleStb = 1'b0;
   pqm_pkg::pqm_tri_sample_t voltSamples = '0;
   pqm_pkg::pqm_tri_sample_t curSamples = '0;
   logic [23:0] neutralSample = 24'h00_0000;
   logic [2:0] zeroCross = 3'h0;
   pqm_pkg::pqm_reg_req_t regReq;
   logic [31:0] regRdData;
   logic regRdValid;
   logic event_irq_b_n;
   int num_errors = 0;
   int total_checks = 0;
   logic [31:0] d;
   logic [31:0] m;
   logic [71:0] s;
   always #5 clk_sys = ~clk_sys;
   pqm_monitor #(.CNT_W(8)) pqm_monitor_i (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn),
      .sampleStb(sampleStb), .voltSamples(voltSamples), .curSamples(curSamples),
      .neutralSample(neutralSample), .zeroCross(zeroCross), .regReq(regReq),
      .regRdData(regRdData), .regRdValid(regRdValid), .event_irq_b_n(event_irq_b_n));
   pqm_host_model pqm_host_model_i (.clk_sys(clk_sys), .regReq(regReq),
      .regRdData(regRdData), .regRdValid(regRdValid));
   task automatic close_out;
      if (num_errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [4:0] idx, input logic [31:0] v);
      pqm_host_model_i.wr(idx, v);
   endtask
   task automatic rc(input logic [4:0] idx, input logic [31:0] ex);
      pqm_host_model_i.rd(idx, d);
      `CHK($sformatf("reg %0d", idx), ex, d)
   endtask
   // Sample lanes are {C, B, A}
   task automatic smp(input logic [71:0] v, input logic [71:0] c, input logic [23:0] n);
      @(posedge clk_sys);
      #1 voltSamples = v;
      curSamples = c;
      neutralSample = n;
      sampleStb = 1'b1;
      @(posedge clk_sys);
      #1 sampleStb = 1'b0;
   endtask
   task automatic zc(input logic [2:0] z);
      @(posedge clk_sys);
      #1 zeroCross = z;
      @(posedge clk_sys);
      #1 zeroCross = 3'h0;
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      for (int i = 2; i < 12; i++) rc(i[4:0], 32'h0000_0000);
      rc(5'h1_F, 32'h0000_0000);
      wr(VTH, 32'hFFFF_FFFF);
      rc(VTH, 32'h00FF_FFFF);
      wr(MTH, 32'hFF80_0000);
      rc(MTH, 32'h0F80_0000);
      wr(SUM, 32'h1234_5678);
      rc(SUM, 32'h0000_0000);
      clkEn = 1'b0;
      wr(VTH, 32'h0000_0000);
      clkEn = 1'b1;
      rc(VTH, 32'h00FF_FFFF);
      wr(VTH, {8'h00, FS});
      wr(ITH, {8'h00, FS});
      wr(MTH, 32'h007F_FFFF);
      wr(ENB, 32'h0196_0000);
      wr(STB, 32'hFFFF_FFFF);
      smp({FS, NFS, FS}, {24'h00_0000, FS, NFS}, 24'h00_0000);
      rc(STB, 32'h0000_0000);
      wr(VTH, 32'h0000_0100);
      wr(ITH, 32'h0000_0100);
      for (int k = 0; k < 2; k++) begin
         for (int p = 0; p < 3; p++) begin
            s = {3{24'h00_0100}};
            s[p * 24 +: 24] = 24'hFF_FEFF;
            m = k ? 32'h0002_0000 : 32'h0004_0000;
            smp(k ? 72'h0 : s, k ? s : 72'h0, k ? 24'h00_00FF : 24'h00_0000);
            `CHK("irq", 1'b0, event_irq_b_n)
            rc(STB, m);
            rc(PHS, 32'h1 << (k ? 3 + p : 9 + p));
            wr(STB, ~m);
            rc(STB, m);
            wr(STB, m);
            rc(PHS, 32'h0000_0000);
            `CHK("irq", 1'b1, event_irq_b_n)
         end
      end
      wr(ENB, 32'h0000_0000);
      smp({48'h0, 24'h00_0101}, 72'h0, 24'h00_0000);
      `CHK("irq", 1'b1, event_irq_b_n)
      rc(STB, 32'h0004_0000);
      wr(ENB, 32'h0196_0000);
      `CHK("irq", 1'b0, event_irq_b_n)
      wr(STB, 32'hFFFF_FFFF);
      wr(MTH, 32'h0000_0010);
      smp(72'h0, 72'h0, 24'h00_0010);
      rc(STB, 32'h0000_0000);
      smp(72'h0, 72'h0, 24'hFF_FFEF);
      `CHK("irq", 1'b0, event_irq_b_n)
      rc(STB, 32'h0010_0000);
      wr(STB, 32'h0010_0000);
      `CHK("irq", 1'b1, event_irq_b_n)
      wr(MTH, 32'h00FF_FFFF);
      smp(72'h0, 72'h0, 24'h00_0000);
      rc(STB, 32'h0010_0000);
      wr(ITH, {8'h00, FS});
      wr(STA, 32'hFFFF_FFFF);
      smp(72'h0, {3{24'h7F_FFFF}}, 24'h00_0000);
      rc(SUM, 32'h017F_FFFD);
      rc(STA, 32'h0002_0000);
      wr(STA, 32'h0002_0000);
      rc(STA, 32'h0000_0000);
      smp(72'h0, {3{24'hFF_FFFF}}, 24'h00_0000);
      rc(SUM, 32'h0FFF_FFFD);
      wr(MTH, 32'h007F_FFFF);
      wr(VTH, {8'h00, FS});
      wr(ENB, 32'h0180_0000);
      wr(STB, 32'hFFFF_FFFF);
      wr(`PQM_IDX_MODE, 32'h0000_000C);
      repeat (3) zc(3'b001);
      wr(`PQM_IDX_HALF_CYC, 32'h0000_0004);
      zc(3'b001);
      zc(3'b100);
      smp({24'h00_0000, 24'h00_0200, 24'hFF_FD00}, {24'h00_9000, 24'h00_0500, 24'h00_0100},
         24'h00_9600);
      zc(3'b010);
      zc(3'b001);
      rc(STB, 32'h0000_0000);
      zc(3'b010);
      `CHK("irq", 1'b0, event_irq_b_n)
      rc(STB, 32'h0180_0000);
      rc(VPK, 32'h0100_0300);
      rc(IPK, 32'h0200_0500);
      wr(STB, 32'h0180_0000);
      smp({24'h00_7000, 24'h00_0050, 24'h00_0000}, {48'h0, 24'h00_0060}, 24'h00_0060);
      rc(VPK, 32'h0100_0300);
      zc(3'b011);
      rc(STB, 32'h0000_0000);
      zc(3'b011);
      rc(STB, 32'h0180_0000);
      rc(VPK, 32'h0200_0050);
      rc(IPK, 32'h0100_0060);
      close_out();
   end
   initial begin
      #200_000;
      num_errors++;
      close_out();
   end
endmodule // pqm_monitor_tb
